// ---- pad_and_fault_status_readback.sv ----
// Functional notes
// - pad readback shows raw pin levels before deglitch; read only.
// - pad bit 15 is 0 while power-good pin is pulled low.
// - pad bit 14 is 0 while alert pin is pulled low.
// - bits 13:12 fault-bus drive, upper pin 0, lower pin 1; 0 is pulled low.
// - bits 11:10 channel-good drive, upper pin 1, lower pin 0; 0 is pulled low.
// - select fields 9:8 pin 1, 7:6 pin 0; 11 high, 10 float, 00 low.
// - bits 5 and 4 are channel-on pin 1 and 0 levels.
// - bits 3:2 fault-bus levels (upper pin 0), bits 1:0 channel-good levels.
// - common readback is the only command answered while busy.
// - busy device refuses other commands and sets busy status flags.
// - common bit 7 is 1 when alert is released high, 0 when low.
// - common bit 6 is 1 when commands are accepted, 0 when busy.
// - common bits 5:2 always read ones.
// - common bit 1 is 1 while shared timebase is held low.
// - common bit 0 mirrors the write-protect pin level.
// - sticky bits hold until fault clear or channel on; alerting ones pull alert.
// - extra fault bits 15:3 read zero.
// - bit 2 per page short-cycle fault, sticky and alerting.
// - bit 1 shared, shows auxiliary fault pin pulled low, not sticky.
// - bit 0 per page sticky input-voltage-off flag, no alert.
// - first-fault record captures first shutdown fault; clears on fault clear or on-cycle.
// - first fault stores low timer byte as timestamp; cleared with the record.
// - record holds page 15:12, bit number 11:8, command code 7:0.
//
// Purpose: read-only pad, common state and extra fault status for a two-channel manager
// Assumes: all inputs synchronous to clock; command port driven by the serial engine
// Notes: answers one cycle after a request; only the busy and known-code checks are done here
`timescale 1ns/100ps
`default_nettype none
`include "pad_fault_defs.svh"

module pad_and_fault_status_readback (
  input wire logic clock,
  input wire logic rst,
  input wire pad_fault_pkg::pad_in_t pads,
  input wire logic other_alert_req,
  input wire logic device_busy,
  input wire pad_fault_pkg::cmd_req_t cmd_req,
  input wire logic clear_faults,
  input wire logic [1:0] channel_turned_on,
  input wire logic [1:0] short_cycle_evt,
  input wire logic [1:0] vin_off_evt,
  input wire logic fault_off_evt,
  input wire pad_fault_pkg::fault_rec_t fault_off_info,
  output pad_fault_pkg::cmd_rsp_t cmd_rsp,
  output logic busy_flag_set,
  output logic alert_pull_low,
  output pad_fault_pkg::fault_rec_t first_fault,
  output logic [7:0] first_fault_timestamp
);

  // ----------------------------------------------------------------
  // shared timebase watch and timer
  // ----------------------------------------------------------------
  localparam int unsigned HOLD_CYC = `SHARE_HOLD_CYC;

  logic share_prev_r;
  logic [15:0] share_idle_r;
  logic share_held_r;
  logic [7:0] shared_timer_r;
  logic share_rise;

  assign share_rise = pads.share_clk_level & ~share_prev_r;

  // previous level resets low, so a pin already high at release counts as one rise
  always_ff @(posedge clock) begin
    if (rst) begin
      share_prev_r <= 1'b0;
    end else begin
      share_prev_r <= pads.share_clk_level;
    end
  end

  // a timebase stalled low is flagged after a full hold window with no rising edge; reset starts it flagged
  always_ff @(posedge clock) begin
    if (rst) begin
      share_idle_r <= 16'h0000;
      share_held_r <= 1'b1;
    end else if (share_rise) begin
      share_idle_r <= 16'h0000;
      share_held_r <= 1'b0;
    end else if (share_idle_r >= HOLD_CYC[15:0]) begin
      share_held_r <= ~pads.share_clk_level;
    end else begin
      share_idle_r <= share_idle_r + 16'h0001;
    end
  end

  // only the low byte of the shared timer is kept; the timestamp needs no more
  always_ff @(posedge clock) begin
    if (rst) begin
      shared_timer_r <= 8'h00;
    end else if (share_rise) begin
      shared_timer_r <= shared_timer_r + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // per-channel sticky fault flags
  // ----------------------------------------------------------------
  logic [1:0] short_cycle_r;
  logic [1:0] vin_off_r;

  // one flag pair per page; the readback picks the page named in the request
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      // set wins over a clear in the same cycle so no event is lost
      always_ff @(posedge clock) begin
        if (rst) begin
          short_cycle_r[ch] <= 1'b0;
          vin_off_r[ch] <= 1'b0;
        end else begin
          if (short_cycle_evt[ch]) begin
            short_cycle_r[ch] <= 1'b1;
          end else if (clear_faults || channel_turned_on[ch]) begin
            short_cycle_r[ch] <= 1'b0;
          end
          if (vin_off_evt[ch]) begin
            vin_off_r[ch] <= 1'b1;
          end else if (clear_faults || channel_turned_on[ch]) begin
            vin_off_r[ch] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // alert output
  // ----------------------------------------------------------------
  // the short-cycle flag is the only alerting source kept in this block
  // registered so both readbacks report the level that the pin shows
  always_ff @(posedge clock) begin
    if (rst) begin
      alert_pull_low <= 1'b0;
    end else begin
      alert_pull_low <= other_alert_req | (|short_cycle_r);
    end
  end

  // ----------------------------------------------------------------
  // first-fault record and timestamp
  // ----------------------------------------------------------------
  logic ff_captured_r;
  logic ff_clear;

  // the record is shared, so either channel turning on clears it
  assign ff_clear = clear_faults | (|channel_turned_on);

  // a fault in the clearing cycle is captured; it is newer than the clear
  always_ff @(posedge clock) begin
    if (rst) begin
      ff_captured_r <= 1'b0;
      first_fault <= `FIRST_FAULT_RST;
      first_fault_timestamp <= `TIMESTAMP_RST;
    end else if (fault_off_evt && (!ff_captured_r || ff_clear)) begin
      ff_captured_r <= 1'b1;
      first_fault <= fault_off_info;
      first_fault_timestamp <= shared_timer_r;
    end else if (ff_clear) begin
      ff_captured_r <= 1'b0;
      first_fault <= `FIRST_FAULT_RST;
      first_fault_timestamp <= `TIMESTAMP_RST;
    end
  end

  // ----------------------------------------------------------------
  // address select decode
  // ----------------------------------------------------------------
  wire [1:0] sel_code [2];

  // float wins over high, so the reserved code 01 is never produced
  function automatic logic [1:0] asel_code(input logic hi, input logic flt);
    logic [1:0] c;
    if (flt) begin
      c = `ASEL_FLOAT;
    end else if (hi) begin
      c = `ASEL_HIGH;
    end else begin
      c = `ASEL_LOW;
    end
    return c;
  endfunction

  genvar sp;
  generate
    for (sp = 0; sp < 2; sp++) begin : g_sel
      assign sel_code[sp] = asel_code(pads.addr_select_high[sp],
        pads.addr_select_float[sp]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // pad state word
  // ----------------------------------------------------------------
  logic [15:0] pad_word;

  // raw levels straight from the pads, no filter in the path
  always_comb begin
    pad_word = 16'h0000;
    pad_word[`PAD_PG_DRV_BIT] = ~pads.pgood_pull_low;
    pad_word[`PAD_ALERT_DRV_BIT] = ~alert_pull_low;
    pad_word[`PAD_FB_DRV_LSB+1] = ~pads.fault_bus_pull_low[0];
    pad_word[`PAD_FB_DRV_LSB] = ~pads.fault_bus_pull_low[1];
    pad_word[`PAD_CG_DRV_LSB+1] = ~pads.channel_good_pull_low[1];
    pad_word[`PAD_CG_DRV_LSB] = ~pads.channel_good_pull_low[0];
    pad_word[`PAD_SEL1_LSB+:2] = sel_code[1];
    pad_word[`PAD_SEL0_LSB+:2] = sel_code[0];
    pad_word[`PAD_CON_LSB+1] = pads.channel_on_level[1];
    pad_word[`PAD_CON_LSB] = pads.channel_on_level[0];
    pad_word[`PAD_FB_LVL_LSB+1] = pads.fault_bus_level[0];
    pad_word[`PAD_FB_LVL_LSB] = pads.fault_bus_level[1];
    pad_word[`PAD_CG_LVL_LSB+1] = pads.channel_good_level[1];
    pad_word[`PAD_CG_LVL_LSB] = pads.channel_good_level[0];
  end

  // ----------------------------------------------------------------
  // common state word
  // ----------------------------------------------------------------
  logic [7:0] common_word;

  always_comb begin
    common_word = 8'h00;
    common_word[`COM_ALERT_BIT] = ~alert_pull_low;
    common_word[`COM_AVAIL_BIT] = ~device_busy;
    common_word[`COM_RSVD_LSB+:4] = `COM_RSVD_VAL;
    common_word[`COM_SHARE_BIT] = share_held_r;
    common_word[`COM_WP_BIT] = pads.write_protect_level;
  end

  // ----------------------------------------------------------------
  // extra fault word
  // ----------------------------------------------------------------
  logic [15:0] extra_word;

  // per-page bits follow the page of the request being answered
  always_comb begin
    extra_word = 16'h0000;
    extra_word[`XF_SHORT_BIT] = short_cycle_r[cmd_req.page];
    extra_word[`XF_AUX_BIT] = pads.aux_fault_pull_low;
    extra_word[`XF_VIN_BIT] = vin_off_r[cmd_req.page];
  end

  // ----------------------------------------------------------------
  // command answer
  // ----------------------------------------------------------------
  logic known_cmd;
  logic refuse;

  // an unknown code gets no acknowledge and zero data, busy or not
  assign known_cmd = (cmd_req.code == `CMD_PAD_STATE) || (cmd_req.code == `CMD_COMMON_STATE)
    || (cmd_req.code == `CMD_EXTRA_FAULT) || (cmd_req.code == `CMD_FIRST_FAULT);
  // polling availability must work while busy, so the common word bypasses the check
  assign refuse = device_busy && (cmd_req.code != `CMD_COMMON_STATE);

  // refusal pulse for the summary busy flags, standing with the answer
  always_ff @(posedge clock) begin
    if (rst) begin
      busy_flag_set <= 1'b0;
    end else begin
      busy_flag_set <= cmd_req.valid && refuse;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cmd_rsp <= '0;
    end else begin
      cmd_rsp.valid <= cmd_req.valid;
      cmd_rsp.ack <= cmd_req.valid && known_cmd && !refuse;
      cmd_rsp.data <= 16'h0000;
      if (cmd_req.valid && !refuse) begin
        case (cmd_req.code)
          `CMD_PAD_STATE: begin
            cmd_rsp.data <= pad_word;
          end
          `CMD_COMMON_STATE: begin
            cmd_rsp.data <= {8'h00, common_word};
          end
          `CMD_EXTRA_FAULT: begin
            cmd_rsp.data <= extra_word;
          end
          `CMD_FIRST_FAULT: begin
            cmd_rsp.data <= first_fault;
          end
          default: begin
            cmd_rsp.data <= 16'h0000;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ---- pad_and_fault_status_readback_tb_top.sv ----
// Purpose: self-checking bench of the pad and fault readback block
// Assumes: 125 MHz clock, inputs driven 1 ns after the rising edge
// Notes: timer expectation is counted here from the share pin itself
`timescale 1ns/100ps
`default_nettype none
module pad_and_fault_status_readback_tb_top;
  typedef struct packed {
    pad_fault_pkg::pad_in_t p;
    logic b;
    logic [7:0] c;
    logic a;
    logic [15:0] d;
  } row_t;
  logic clock, rst, other_alert_req, device_busy, clear_faults, fault_off_evt, go, page;
  logic busy_flag_set, alert_pull_low, share_q;
  logic [1:0] channel_turned_on, short_cycle_evt, vin_off_evt;
  logic [7:0] code, rises, first_fault_timestamp;
  pad_fault_pkg::pad_in_t pads;
  pad_fault_pkg::fault_rec_t fault_off_info, first_fault;
  pad_fault_pkg::cmd_req_t cmd_req;
  pad_fault_pkg::cmd_rsp_t cmd_rsp;
  int fail_count, samples_checked;
  // pads, busy, code, ack, data
  row_t rows [11] = '{'{18'h00000, 1'b0, 8'hE0, 1'b1, 16'hFC00},
    '{18'h00000, 1'b0, 8'hE1, 1'b1, 16'h00FE}, '{18'h3FFFF, 1'b0, 8'hE0, 1'b1, 16'h42BF},
    '{18'h3FFFF, 1'b0, 8'hE1, 1'b1, 16'h00FD}, '{18'h3FFFF, 1'b1, 8'hE1, 1'b1, 16'h00BD},
    '{18'h3FFFF, 1'b1, 8'hE0, 1'b0, 16'h0000}, '{18'h3FFFF, 1'b0, 8'hE2, 1'b1, 16'h0002},
    '{18'h0A8A8, 1'b0, 8'hE0, 1'b1, 16'hD8D9}, '{18'h01200, 1'b0, 8'hE0, 1'b1, 16'hFF80},
    '{18'h01200, 1'b0, 8'h55, 1'b0, 16'h0000}, '{18'h01200, 1'b1, 8'hE3, 1'b0, 16'h0000}};
  pad_fault_host host (.go, .code, .page, .cmd_req);
  pad_and_fault_status_readback uut (.clock, .rst, .pads, .other_alert_req, .device_busy,
    .cmd_req, .clear_faults, .channel_turned_on, .short_cycle_evt, .vin_off_evt, .fault_off_evt,
    .fault_off_info, .cmd_rsp, .busy_flag_set, .alert_pull_low, .first_fault,
    .first_fault_timestamp);
  always #4 clock = ~clock;
  always @(posedge clock) begin
    share_q <= pads.share_clk_level;
    if (rst) rises <= 8'h00;
    else if (pads.share_clk_level && !share_q) rises <= rises + 8'h01;
  end
  task tick();
    @(posedge clock);
    #1;
  endtask
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task chb(input string n, input logic e, input logic s);
    chk(n, {15'h0000, e}, {15'h0000, s});
  endtask
  task rd(input logic [7:0] c, input logic p, input logic xa, input logic [15:0] xd,
          input logic xb);
    code = c;
    page = p;
    go = 1'b1;
    tick();
    chb("valid", 1'b1, cmd_rsp.valid);
    chb("ack", xa, cmd_rsp.ack);
    chk("data", xd, cmd_rsp.data);
    chb("busy_flag", xb, busy_flag_set);
  endtask
  // v = {fault, clear, on[1:0], short[1:0], vin[1:0]}, one-cycle pulses
  task ev(input logic [7:0] v);
    go = 1'b0;
    {fault_off_evt, clear_faults, channel_turned_on, short_cycle_evt, vin_off_evt} = v;
    tick();
    {fault_off_evt, clear_faults, channel_turned_on, short_cycle_evt, vin_off_evt} = 8'h00;
    tick();
  endtask
  task close_out();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clock);
    fail_count++;
    close_out();
  end
  // ----------------
  // stimulus
  // ----------------
  initial begin
    {clock, other_alert_req, device_busy, go, page, code, pads, fault_off_info} = '0;
    {fail_count, samples_checked} = '0;
    rst = 1'b1;
    ev(8'h00);
    repeat (3) tick();
    rst = 1'b0;
    foreach (rows[i]) begin
      go = 1'b0;
      pads = rows[i].p;
      device_busy = rows[i].b;
      repeat (3) tick();
      rd(rows[i].c, 1'b0, rows[i].a, rows[i].d, rows[i].b && rows[i].c != 8'hE1);
    end
    device_busy = 1'b0;
    $display("table done");
    ev(8'h08);
    chb("alert", 1'b1, alert_pull_low);
    rd(8'hE2, 1'b1, 1'b1, 16'h0004, 1'b0);
    rd(8'hE2, 1'b0, 1'b1, 16'h0000, 1'b0);
    rd(8'hE0, 1'b0, 1'b1, 16'hBF80, 1'b0);
    ev(8'h20);
    rd(8'hE2, 1'b1, 1'b1, 16'h0000, 1'b0);
    ev(8'h01);
    chb("alert", 1'b0, alert_pull_low);
    rd(8'hE2, 1'b0, 1'b1, 16'h0001, 1'b0);
    ev(8'h40);
    rd(8'hE2, 1'b0, 1'b1, 16'h0000, 1'b0);
    $display("sticky done");
    go = 1'b0;
    repeat (5) begin
      pads.share_clk_level = 1'b1;
      repeat (2) tick();
      pads.share_clk_level = 1'b0;
      repeat (2) tick();
    end
    rd(8'hE1, 1'b0, 1'b1, 16'h00FC, 1'b0);
    fault_off_info = 16'h1280;
    ev(8'h80);
    fault_off_info = 16'h0A7A;
    ev(8'h80);
    chk("first", 16'h1280, first_fault);
    chk("stamp", {8'h00, rises}, {8'h00, first_fault_timestamp});
    rd(8'hE3, 1'b0, 1'b1, 16'h1280, 1'b0);
    ev(8'h10);
    chk("first", 16'h0000, first_fault);
    chk("stamp", 16'h0000, {8'h00, first_fault_timestamp});
    fault_off_info = 16'hF003;
    ev(8'hC0);
    chk("first", 16'hF003, first_fault);
    ev(8'h40);
    chk("first", 16'h0000, first_fault);
    $display("first fault done");
    repeat (260) tick();
    rd(8'hE1, 1'b0, 1'b1, 16'h00FE, 1'b0);
    other_alert_req = 1'b1;
    tick();
    rd(8'hE1, 1'b0, 1'b1, 16'h007E, 1'b0);
    other_alert_req = 1'b0;
    ev(8'h80);
    rst = 1'b1;
    repeat (2) tick();
    rst = 1'b0;
    chk("first", 16'h0000, first_fault);
    rd(8'hE1, 1'b0, 1'b1, 16'h00FE, 1'b0);
    $display("reset done");
    close_out();
  end
endmodule
`default_nettype wire

// ---- pad_fault_defs.svh ----
// Purpose: offsets, field positions, reset values and timing counts of the pad and fault status block
// Assumes: 125 MHz system clock
// Notes: command codes are the block's own select values on the internal command port
`ifndef PAD_FAULT_DEFS_SVH
`define PAD_FAULT_DEFS_SVH

`define CMD_PAD_STATE 8'hE0
`define CMD_COMMON_STATE 8'hE1
`define CMD_EXTRA_FAULT 8'hE2
`define CMD_FIRST_FAULT 8'hE3

`define PAD_PG_DRV_BIT 15
`define PAD_ALERT_DRV_BIT 14
`define PAD_FB_DRV_LSB 12
`define PAD_CG_DRV_LSB 10
`define PAD_SEL1_LSB 8
`define PAD_SEL0_LSB 6
`define PAD_CON_LSB 4
`define PAD_FB_LVL_LSB 2
`define PAD_CG_LVL_LSB 0

`define COM_ALERT_BIT 7
`define COM_AVAIL_BIT 6
`define COM_RSVD_LSB 2
`define COM_RSVD_VAL 4'hF
`define COM_SHARE_BIT 1
`define COM_WP_BIT 0

`define XF_SHORT_BIT 2
`define XF_AUX_BIT 1
`define XF_VIN_BIT 0

`define ASEL_HIGH 2'h3
`define ASEL_FLOAT 2'h2
`define ASEL_LOW 2'h0

`define FIRST_FAULT_RST 16'h0000
`define TIMESTAMP_RST 8'h00
`define CLK_MHZ 125
`define SHARE_HOLD_NS 2000
`define SHARE_HOLD_CYC ((`SHARE_HOLD_NS * `CLK_MHZ) / 1000)

`endif

// ---- pad_fault_host.sv ----
// Purpose: host side of the internal command port
// Assumes: go is raised just after a clock edge
// Notes: code is inverted while idle so stale values never pass as valid
`timescale 1ns/100ps
`default_nettype none
module pad_fault_host (
  input wire logic go,
  input wire logic [7:0] code,
  input wire logic page,
  output var pad_fault_pkg::cmd_req_t cmd_req
);
  assign cmd_req = {go, go ? code : ~code, page};
endmodule
`default_nettype wire

// ---- pad_fault_monitor.sv ----
// Purpose: port checks of the pad and fault readback block
// Assumes: one clock, synchronous reset
// Notes: bound to every instance of the block
`timescale 1ns/100ps
`default_nettype none
`include "pad_fault_defs.svh"
module pad_fault_monitor (
  input wire logic clock,
  input wire logic rst,
  input wire pad_fault_pkg::pad_in_t pads,
  input wire logic other_alert_req,
  input wire logic device_busy,
  input wire pad_fault_pkg::cmd_req_t cmd_req,
  input wire logic clear_faults,
  input wire logic [1:0] channel_turned_on,
  input wire logic [1:0] short_cycle_evt,
  input wire logic [1:0] vin_off_evt,
  input wire logic fault_off_evt,
  input wire pad_fault_pkg::fault_rec_t fault_off_info,
  input wire pad_fault_pkg::cmd_rsp_t cmd_rsp,
  input wire logic busy_flag_set,
  input wire logic alert_pull_low,
  input wire pad_fault_pkg::fault_rec_t first_fault,
  input wire logic [7:0] first_fault_timestamp
);
  // ----------------
  // checks
  // ----------------
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_req(c);
    cmd_req.valid && !device_busy && cmd_req.code == c;
  endsequence
  sequence s_clear;
    (clear_faults || channel_turned_on != 2'h0) && !fault_off_evt;
  endsequence
  a_rsp_one_cycle: assert property (cmd_rsp.valid == $past(cmd_req.valid))
    else $error("answer not one cycle after request");
  a_busy_refuse: assert property (cmd_req.valid && device_busy &&
    cmd_req.code != `CMD_COMMON_STATE |=> !cmd_rsp.ack && busy_flag_set && cmd_rsp.data == 16'h0)
    else $error("busy refusal wrong");
  a_common_busy: assert property (cmd_req.valid && cmd_req.code == `CMD_COMMON_STATE
    |=> cmd_rsp.ack && cmd_rsp.data[6] == !$past(device_busy))
    else $error("common word not answered or busy bit wrong");
  a_common_rsvd: assert property (s_req(`CMD_COMMON_STATE)
    |=> cmd_rsp.data[5:2] == 4'hF && cmd_rsp.data[15:8] == 8'h00)
    else $error("common reserved bits wrong");
  a_pad_raw: assert property (s_req(`CMD_PAD_STATE) |=>
    cmd_rsp.data[15] == !$past(pads.pgood_pull_low) && cmd_rsp.data[14] == !$past(alert_pull_low)
    && cmd_rsp.data[5:4] == $past(pads.channel_on_level))
    else $error("pad word wrong");
  a_extra_rsvd: assert property (s_req(`CMD_EXTRA_FAULT) |=>
    cmd_rsp.data[15:3] == 13'h0 && cmd_rsp.data[1] == $past(pads.aux_fault_pull_low))
    else $error("extra fault word wrong");
  a_short_alert: assert property (short_cycle_evt != 2'h0 |-> ##2 alert_pull_low)
    else $error("short cycle did not pull alert");
  a_first_capture: assert property (fault_off_evt && first_fault == 16'h0
    |=> first_fault == $past(fault_off_info))
    else $error("first fault not captured");
  a_first_clear: assert property (s_clear |=>
    first_fault == 16'h0 && first_fault_timestamp == 8'h00)
    else $error("first fault not cleared");
endmodule
bind pad_and_fault_status_readback pad_fault_monitor mon (.clock, .rst, .pads, .other_alert_req,
  .device_busy, .cmd_req, .clear_faults, .channel_turned_on, .short_cycle_evt, .vin_off_evt,
  .fault_off_evt, .fault_off_info, .cmd_rsp, .busy_flag_set, .alert_pull_low, .first_fault,
  .first_fault_timestamp);
`default_nettype wire

// ---- pad_fault_pkg.sv ----
// Purpose: types shared by the pad and fault status block
// Assumes: two channels
// Notes: constants live in pad_fault_defs.svh
`default_nettype none
package pad_fault_pkg;

  // raw pad levels and this chip's own pull-downs, before deglitching
  typedef struct packed {
    logic pgood_pull_low;
    logic [1:0] fault_bus_pull_low;
    logic [1:0] channel_good_pull_low;
    logic [1:0] addr_select_high;
    logic [1:0] addr_select_float;
    logic [1:0] channel_on_level;
    logic [1:0] fault_bus_level;
    logic [1:0] channel_good_level;
    logic write_protect_level;
    logic share_clk_level;
    logic aux_fault_pull_low;
  } pad_in_t;

  typedef struct packed {
    logic [3:0] page;
    logic [3:0] bit_num;
    logic [7:0] cmd;
  } fault_rec_t;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic page;
  } cmd_req_t;

  typedef struct packed {
    logic valid;
    logic ack;
    logic [15:0] data;
  } cmd_rsp_t;

endpackage
`default_nettype wire
